// [src/seci_cfg.svh]
`ifndef SECI_CFG_SVH
`define SECI_CFG_SVH
`define SECI_OP_WREN        8'h06
`define SECI_OP_WRDI        8'h04
`define SECI_OP_RDSR        8'h05
`define SECI_OP_WRSR        8'h01
`define SECI_OP_READ        8'h03
`define SECI_OP_WRITE       8'h02
`define SECI_OP_MEM_MASK    8'hF7
`define SECI_OP_A8_BIT      3
`define SECI_CLK_HZ         20000000
`define SECI_WRITE_TIME_MS  5
`define SECI_WRITE_CYCLES   ((`SECI_WRITE_TIME_MS * `SECI_CLK_HZ) / 1000)
`define SECI_SR_FIXED       4'hF
`define SECI_SR_BP_RESET    2'h0
`define SECI_MEM_DEPTH      512
`define SECI_ADDR_W         9
`define SECI_SYNC_SLACK     5
`endif

// [src/seci_pkg.sv]
package seci_pkg;
  typedef enum logic [2:0] {
    SECI_OP_NONE, SECI_OP_EN, SECI_OP_DIS, SECI_OP_RDST, SECI_OP_WRST, SECI_OP_RDMEM, SECI_OP_WRMEM
  } seci_op_e;
  typedef enum logic [2:0] {
    SECI_ST_OPCODE, SECI_ST_ADDR, SECI_ST_DATA_IN, SECI_ST_DATA_OUT, SECI_ST_IGNORE
  } seci_state_e;
  typedef struct packed {
    logic       we;
    logic [8:0] addr;
    logic [7:0] wdata;
  } seci_mem_req_s;
endpackage

// [src/seci_mem.sv]
`timescale 1ns/10ps
`include "seci_cfg.svh"
module seci_mem (
  input  wire logic                   clk_in,  // system clock
  input  wire seci_pkg::seci_mem_req_s req_in,  // write strobe, address, data
  output logic [7:0]                  rdata_out // registered read data
);
  logic [7:0] store [0:`SECI_MEM_DEPTH-1];

  always_ff @(posedge clk_in) begin
    if (req_in.we) begin
      store[req_in.addr] <= req_in.wdata;
    end
    rdata_out <= store[req_in.addr];
  end
endmodule // seci_mem

// [src/seci_top.sv]
`timescale 1ns/10ps
`include "seci_cfg.svh"
module seci_top (
  input  wire logic CLK_IN,    // 20 MHz system clock
  input  wire logic RST_IN,    // synchronous reset, active high
  input  wire logic CS_N_IN,   // chip select, active low
  input  wire logic SCK_IN,    // serial clock from host
  input  wire logic SI_IN,     // serial data in
  input  wire logic WP_N_IN,   // write protect, active low
  input  wire logic HOLD_N_IN, // hold, active low
  output logic      SO_OUT,    // serial data out
  output logic      SO_OE_OUT, // high while driving serial out
  output logic      BUSY_OUT   // internal write cycle running
);
  localparam int WRITE_CYCLES = `SECI_WRITE_CYCLES;
  // select reaches the logic through the synchroniser, so the count ends early to stay inside the limit
  localparam int WRITE_LAST   = `SECI_WRITE_CYCLES - `SECI_SYNC_SLACK;

  logic [1:0] cs_s, sck_s, si_s, wp_s, hold_s;
  logic       sck_d, cs_d;
  logic       rise, fall, sel, held, cs_rise;
  logic [2:0] bit_cnt;
  logic [7:0] shreg, opcode, out_byte;
  logic [8:0] addr;
  logic [7:0] wdata;
  logic       wel, wr_pending, wr_is_sr, mem_we, so_live;
  logic [8:0] wr_addr;
  logic [7:0] wr_data;
  logic [1:0] bp;
  logic [31:0] wcnt;
  logic [7:0] rdata;
  logic [7:0] status;
  seci_pkg::seci_state_e state;
  seci_pkg::seci_op_e    op;
  seci_pkg::seci_mem_req_s mreq;

  function automatic seci_pkg::seci_op_e decode(input logic [7:0] c);
    if (c == `SECI_OP_WREN) return seci_pkg::SECI_OP_EN;
    if (c == `SECI_OP_WRDI) return seci_pkg::SECI_OP_DIS;
    if (c == `SECI_OP_RDSR) return seci_pkg::SECI_OP_RDST;
    if (c == `SECI_OP_WRSR) return seci_pkg::SECI_OP_WRST;
    if ((c & `SECI_OP_MEM_MASK) == `SECI_OP_READ) return seci_pkg::SECI_OP_RDMEM;
    if ((c & `SECI_OP_MEM_MASK) == `SECI_OP_WRITE) return seci_pkg::SECI_OP_WRMEM;
    return seci_pkg::SECI_OP_NONE;
  endfunction

  // pins are asynchronous to CLK_IN: two flops before use
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      cs_s <= 2'h3; sck_s <= 2'h0; si_s <= 2'h0; wp_s <= 2'h0; hold_s <= 2'h3;
    end else begin
      cs_s <= {cs_s[0], CS_N_IN}; sck_s <= {sck_s[0], SCK_IN}; si_s <= {si_s[0], SI_IN};
      wp_s <= {wp_s[0], WP_N_IN}; hold_s <= {hold_s[0], HOLD_N_IN};
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end else begin
      sck_d <= sck_s[1];
      cs_d  <= cs_s[1];
    end
  end

  assign sel     = !cs_s[1];
  assign held    = !hold_s[1];
  assign rise    = sel && !held && sck_s[1] && !sck_d;
  assign fall    = sel && !held && !sck_s[1] && sck_d;
  assign cs_rise = cs_s[1] && !cs_d;
  assign op      = decode(opcode);
  assign status  = {`SECI_SR_FIXED, bp, wel, wr_pending};

  // bit shifting and session sequencing
  always_ff @(posedge CLK_IN) begin
    if (RST_IN || !sel) begin
      bit_cnt <= 3'h0;
      shreg   <= 8'h00;
      opcode  <= 8'h00;
      state   <= seci_pkg::SECI_ST_OPCODE;
      addr    <= 9'h000;
      wdata   <= 8'h00;
    end else if (rise) begin
      shreg   <= {shreg[6:0], si_s[1]};
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        unique case (state)
          seci_pkg::SECI_ST_OPCODE: begin
            opcode <= {shreg[6:0], si_s[1]};
            unique case (decode({shreg[6:0], si_s[1]}))
              seci_pkg::SECI_OP_RDMEM, seci_pkg::SECI_OP_WRMEM: begin
                state   <= wr_pending ? seci_pkg::SECI_ST_IGNORE : seci_pkg::SECI_ST_ADDR;
                addr[8] <= shreg[`SECI_OP_A8_BIT-1];
              end
              seci_pkg::SECI_OP_RDST: state <= seci_pkg::SECI_ST_DATA_OUT;
              seci_pkg::SECI_OP_WRST: state <= wr_pending ? seci_pkg::SECI_ST_IGNORE : seci_pkg::SECI_ST_DATA_IN;
              seci_pkg::SECI_OP_EN, seci_pkg::SECI_OP_DIS: state <= seci_pkg::SECI_ST_IGNORE;
              seci_pkg::SECI_OP_NONE: state <= seci_pkg::SECI_ST_IGNORE;
            endcase
          end
          seci_pkg::SECI_ST_ADDR: begin
            addr[7:0] <= {shreg[6:0], si_s[1]};
            state <= (op == seci_pkg::SECI_OP_RDMEM) ? seci_pkg::SECI_ST_DATA_OUT : seci_pkg::SECI_ST_DATA_IN;
          end
          seci_pkg::SECI_ST_DATA_IN: begin
            wdata <= {shreg[6:0], si_s[1]};
            state <= seci_pkg::SECI_ST_IGNORE; // single byte per session
          end
          seci_pkg::SECI_ST_DATA_OUT: begin
            if (op == seci_pkg::SECI_OP_RDMEM) begin
              addr <= addr + 9'h001;
            end
          end
          seci_pkg::SECI_ST_IGNORE: ;
        endcase
      end
    end
  end

  // remembers that output has begun, so the driver comes back after a hold pause
  always_ff @(posedge CLK_IN) begin
    if (RST_IN || !sel) begin
      so_live <= 1'b0;
    end else if (fall && state == seci_pkg::SECI_ST_DATA_OUT) begin
      so_live <= 1'b1;
    end
  end

  // output shifter: a fresh byte is loaded after the last bit of the previous one
  always_ff @(posedge CLK_IN) begin
    if (RST_IN || !sel) begin
      out_byte <= 8'hFF;
    end else if (fall && bit_cnt == 3'h0) begin
      if (op == seci_pkg::SECI_OP_RDST) begin
        out_byte <= {status[6:0], 1'b1};
      end else begin
        out_byte <= {rdata[6:0], 1'b1};
      end
    end else if (fall) begin
      out_byte <= {out_byte[6:0], 1'b1};
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN || !sel) begin
      SO_OUT    <= 1'b0;
      SO_OE_OUT <= 1'b0;
    end else if (fall) begin
      SO_OE_OUT <= (state == seci_pkg::SECI_ST_DATA_OUT);
      SO_OUT    <= (bit_cnt == 3'h0) ? ((op == seci_pkg::SECI_OP_RDST) ? status[7] : rdata[7]) : out_byte[7];
    end else if (held) begin
      SO_OE_OUT <= 1'b0;
    end else if (state == seci_pkg::SECI_ST_DATA_OUT && !SO_OE_OUT && so_live) begin
      SO_OE_OUT <= 1'b1;
    end
  end

  // commit decisions at select rising edge
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      wel        <= 1'b0;
      bp         <= `SECI_SR_BP_RESET;
      wr_pending <= 1'b0;
      wr_is_sr   <= 1'b0;
      wcnt       <= 32'h0;
      wr_addr    <= 9'h000;
      wr_data    <= 8'h00;
    end else if (wr_pending) begin
      if (wcnt == WRITE_LAST) begin
        wr_pending <= 1'b0;
        wel        <= 1'b0;
        if (wr_is_sr) begin
          bp <= wr_data[3:2];
        end
      end
      wcnt <= wcnt + 32'h1;
    end else if (cs_rise && bit_cnt == 3'h0) begin
      if (op == seci_pkg::SECI_OP_EN && state == seci_pkg::SECI_ST_IGNORE) begin
        wel <= 1'b1;
      end else if (op == seci_pkg::SECI_OP_DIS && state == seci_pkg::SECI_ST_IGNORE) begin
        wel <= 1'b0;
      end else if ((op == seci_pkg::SECI_OP_WRMEM || op == seci_pkg::SECI_OP_WRST) && wel && wp_s[1] &&
                   state == seci_pkg::SECI_ST_IGNORE && opcode != 8'h00) begin
        wr_pending <= 1'b1;
        wr_is_sr   <= (op == seci_pkg::SECI_OP_WRST);
        wcnt       <= 32'h0;
        // session registers clear on deselect, so the write keeps its own copy
        wr_addr    <= addr;
        wr_data    <= wdata;
      end
    end
  end

  // memory write lands on the final cycle of the internal write
  assign mem_we      = wr_pending && !wr_is_sr && wcnt == WRITE_LAST;
  assign mreq.we     = mem_we;
  assign mreq.addr   = mem_we ? wr_addr : addr;
  assign mreq.wdata  = wr_data;
  assign BUSY_OUT    = wr_pending;

  seci_mem u_mem (
    .clk_in    (CLK_IN),
    .req_in    (mreq),
    .rdata_out (rdata)
  );

  chk_float_desel: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    cs_s[1] |=> !SO_OE_OUT) else $error("output driven while deselected");
  chk_hold_float: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    held && !fall |=> !SO_OE_OUT) else $error("output driven during hold");
  chk_write_len: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    $rose(wr_pending) |-> wr_pending[*8]) else $error("write cycle too short");
  chk_wp_block: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !wp_s[1] && !wr_pending |=> !$rose(wr_pending)) else $error("write started while protected");
  chk_so_timing: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    sel && !fall && SO_OE_OUT |=> $stable(SO_OUT)) else $error("output changed off falling edge");
  chk_session_rst: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    cs_rise |=> bit_cnt == 3'h0 && state == seci_pkg::SECI_ST_OPCODE) else $error("session not reset");
  chk_bad_op: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    op == seci_pkg::SECI_OP_NONE && state != seci_pkg::SECI_ST_OPCODE |-> !SO_OE_OUT) else $error("unknown op drove");
  chk_shift_in: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !rise && sel |=> $stable(bit_cnt)) else $error("bit counted without rising edge");
  chk_write_max: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    wr_pending |-> wcnt <= WRITE_LAST) else $error("write cycle overran");
  chk_wel_end: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    $fell(wr_pending) |-> !wel) else $error("latch not cleared after write");
  chk_enable_set: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    cs_rise && !wr_pending && bit_cnt == 3'h0 && op == seci_pkg::SECI_OP_EN &&
    state == seci_pkg::SECI_ST_IGNORE |=> wel) else $error("latch not set");
  chk_status_msb: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    fall && bit_cnt == 3'h0 && state == seci_pkg::SECI_ST_DATA_OUT && op == seci_pkg::SECI_OP_RDST
    |=> SO_OUT == $past(status[7])) else $error("status not msb first");
endmodule // seci_top

// [test/seci_host_model.sv]
`timescale 1ns/10ps
module seci_host_model (
  input  wire logic clk_in,    // bench clock
  input  wire logic so_in,     // device serial out
  input  wire logic so_oe_in,  // device drives serial out
  output logic      cs_n_out,  // chip select, active low
  output logic      sck_out,   // serial clock
  output logic      si_out,    // serial data to device
  output logic      hold_n_out // pause request, active low
);
  logic last_so = 1'b0;
  logic mode3   = 1'b0;
  logic so_wire;
  // a released line shows the inverse of its last level, so a stale copy never passes
  assign so_wire = so_oe_in ? so_in : ~last_so;
  always @(posedge clk_in) if (so_oe_in) last_so <= so_in;
  initial begin
    cs_n_out = 1'b1; sck_out = 1'b0; si_out = 1'b0; hold_n_out = 1'b1;
  end
  task automatic half();
    repeat (4) @(negedge clk_in);
  endtask
  task automatic start(input bit m3);
    mode3 = m3;
    sck_out = m3;
    half();
    cs_n_out = 1'b0;
    half();
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck_out = 1'b0;
      si_out = tx[i];
      half();
      rx[i] = so_wire;
      sck_out = 1'b1;
      half();
    end
  endtask
  task automatic pause(input logic [7:0] noise, output logic oe_seen);
    oe_seen = 1'b0;
    sck_out = 1'b0;
    half();
    hold_n_out = 1'b0;
    for (int i = 0; i < 8; i++) begin
      si_out = noise[i];
      half();
      oe_seen |= so_oe_in;
    end
    hold_n_out = 1'b1;
    half();
  endtask
  task automatic stop();
    if (!mode3) begin
      sck_out = 1'b0;
      half();
    end
    cs_n_out = 1'b1;
    half();
    half();
  endtask
endmodule // seci_host_model

// [test/tb_seci_top.sv]
`timescale 1ns/10ps
`include "seci_cfg.svh"
module tb_seci_top;
  logic        clk, rst, wp_n, so, so_oe, busy_o, oe;
  wire         cs_n, sck, si, hold_n;
  int          failures = 0, checks = 0, wel = 0, busy = 0, cyc = 0, t0;
  logic [7:0]  rx, dat;
  logic [8:0]  addr;
  logic [31:0] lfsr = 32'h0001058B;
  logic [7:0]  bad_ops [4] = '{8'hFF, 8'h85, 8'h0C, 8'h00};
  seci_top DUT (.CLK_IN(clk), .RST_IN(rst), .CS_N_IN(cs_n), .SCK_IN(sck), .SI_IN(si), .WP_N_IN(wp_n),
    .HOLD_N_IN(hold_n), .SO_OUT(so), .SO_OE_OUT(so_oe), .BUSY_OUT(busy_o));
  seci_host_model host (.clk_in(clk), .so_in(so), .so_oe_in(so_oe), .cs_n_out(cs_n), .sck_out(sck),
    .si_out(si), .hold_n_out(hold_n));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [7:0] st();
    return {4'hF, 2'h0, wel[0], busy[0]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic frame(input bit m3, input logic [7:0] b0, b1, b2, input int n, output logic [7:0] r);
    host.start(m3);
    host.xfer(b0, r);
    if (n > 1) host.xfer(b1, r);
    if (n > 2) host.xfer(b2, r);
    host.stop();
    check({7'h00, so_oe}, 8'h00);
  endtask
  initial begin
    repeat (`SECI_WRITE_CYCLES + 20000) @(posedge clk);
    failures++;
    $display("ERROR %0t: run did not finish", $time);
    test_done();
  end
  initial begin
    rst = 1'b1; wp_n = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int m = 0; m < 2; m++) begin
      frame(m, 8'h05, 8'h00, 8'h00, 2, rx); check(rx, st());
      frame(m, 8'h06, 8'h00, 8'h00, 1, rx); wel = 1;
      frame(m, 8'h05, 8'h00, 8'h00, 2, rx); check(rx, st());
      frame(m, 8'h04, 8'h00, 8'h00, 1, rx); wel = 0;
      frame(m, 8'h05, 8'h00, 8'h00, 2, rx); check(rx, st());
    end
    $display("test latch and status done");
    foreach (bad_ops[i]) begin
      host.start(0);
      host.xfer(bad_ops[i], rx);
      host.xfer(8'h00, rx);
      check({7'h00, so_oe}, 8'h00);
      host.stop();
    end
    // status write without the latch set must leave protection bits alone
    frame(0, 8'h01, 8'h0C, 8'h00, 2, rx);
    frame(0, 8'h05, 8'h00, 8'h00, 2, rx); check(rx, st());
    $display("test unknown codes done");
    lfsr = nxt(lfsr);
    addr = lfsr[8:0];
    dat = lfsr[16:9];
    frame(0, 8'h02 | {4'h0, addr[8], 3'h0}, addr[7:0], dat, 3, rx);
    check({7'h00, busy_o}, 8'h00);
    frame(0, 8'h06, 8'h00, 8'h00, 1, rx);
    wp_n = 1'b0;
    frame(0, 8'h02 | {4'h0, addr[8], 3'h0}, addr[7:0], dat, 3, rx);
    wp_n = 1'b1;
    check({7'h00, busy_o}, 8'h00);
    frame(0, 8'h06, 8'h00, 8'h00, 1, rx);
    frame(1, 8'h02 | {4'h0, addr[8], 3'h0}, addr[7:0], dat, 3, rx);
    t0 = cyc - 8;
    check({7'h00, busy_o}, 8'h01);
    frame(0, 8'h05, 8'h00, 8'h00, 2, rx); check({7'h00, rx[0]}, 8'h01);
    while (busy_o !== 1'b0 && cyc - t0 < `SECI_WRITE_CYCLES) @(negedge clk);
    check({7'h00, busy_o}, 8'h00);
    wel = 0;
    frame(0, 8'h05, 8'h00, 8'h00, 2, rx); check(rx, st());
    $display("test write cycle done");
    lfsr = nxt(lfsr);
    host.start(1);
    host.xfer(8'h03 | {4'h0, addr[8], 3'h0}, rx);
    host.xfer(addr[7:0], rx);
    host.pause(lfsr[7:0], oe);
    host.xfer(8'h00, rx);
    host.stop();
    check({7'h00, oe}, 8'h00);
    check(rx, dat);
    $display("test read with pause done");
    test_done();
  end
endmodule // tb_seci_top
